// ==== hw/rtp_cfg.svh ====
// Offsets, field positions, reset values and fixed figures of the register slice.
// Assumes inclusion by bare name from every file that needs them.
`ifndef RTP_CFG_SVH
`define RTP_CFG_SVH

`define RTP_AW 8
`define RTP_OFS_CMD 8'h88
`define RTP_OFS_PERF 8'h8c
`define RTP_OFS_PMCS 8'h90
`define RTP_OFS_ISTAT 8'h94
`define RTP_OFS_IMASK 8'h98

`define RTP_CMD_PAUSE 5
`define RTP_CMD_RTE 4
`define RTP_CMD_DRT_HI 3
`define RTP_CMD_DRT_LO 2
`define RTP_CMD_SOFT_INTERRUPT 1
`define RTP_CMD_AUTO_UNDERRUN_RECOVERY 0

`define RTP_PERF_CLK_HI 31
`define RTP_PERF_CLK_LO 16
`define RTP_PERF_DW_HI 7
`define RTP_PERF_DW_LO 0

`define RTP_PM_WAKE 15
`define RTP_PM_SCALE_HI 14
`define RTP_PM_SCALE_LO 13
`define RTP_PM_SEL_HI 12
`define RTP_PM_SEL_LO 9
`define RTP_PM_WSE 8

`define RTP_IS_WAKE 0
`define RTP_IS_SOFT 1
`define RTP_IS_W 2

`define RTP_RST_PAUSE 1'h0
`define RTP_RST_RTE 1'h0
`define RTP_RST_DRT 2'h1
`define RTP_RST_SOFT_INTERRUPT 1'h0
`define RTP_RST_AUTO_UNDERRUN_RECOVERY 1'h0
`define RTP_RST_MASK 2'h0
`define RTP_DRT_FIXED 2'h1
`define RTP_SCALE_VAL 2'h0
`define RTP_SEL_VAL 4'h0

`define RTP_RESP_OKAY 2'h0
`define RTP_RESP_SLVERR 2'h2

`endif

// ==== hw/rtp_csr_top.sv ====
// Command, performance counter and power management register slice on AXI4-Lite.
// Assumes bus-master activity strobes on mclk and an asynchronous wake pin.
// Function
// - Pause enable loads negotiated value, software-writable
// - Threshold disabled forces fixed 64-byte drain
// - Drain field: 32, 64, store-forward; reset 01
// - Underrun recovery bit enables recovery, resets 0
// - Upper counter sums read-request latency clocks
// - Low counter sums bus-master double words
// - Counter fields read-only, cleared by read
// - Performance counter at byte offset 8ch
// - Wake status set on every wake event
// - Write one clears wake status; zero ignored
// - Data scaling field always reads 00b
// - Data selection field always reads 0000b
// - PME# asserted only while wake enabled
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "rtp_cfg.svh"
module rtp_csr_top
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic an_done,
	input wire logic an_pause,
	input wire logic rd_req_active,
	input wire logic dw_xfer,
	input wire logic wake_event_pin,
	input wire logic wake_signal_enable,
	output logic pause_enable,
	output logic rx_threshold_enable,
	output rtp_pkg::rtp_drain_type rx_drain_threshold,
	output rtp_pkg::rtp_drain_type rx_drain_effective,
	output logic soft_interrupt,
	output logic auto_underrun_recovery,
	output logic pme_n_o,
	output logic pme_n_oe,
	output logic irq
);
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] wa_r;
	logic [31:0] wd_r;
	logic [3:0] ws_r;
	logic wr_fire;
	logic rd_fire;
	rtp_pkg::rtp_reg_type wr_sel;
	rtp_pkg::rtp_reg_type rd_sel;
	rtp_pkg::rtp_rd_state_type rd_state_r;
	logic [31:0] rd_word;
	logic perf_clr;
	logic istat_clr;
	logic [15:0] lat_count;
	logic [7:0] dw_count;
	logic wake_level;
	logic wake_rise;
	logic wake_status_r;
	logic [`RTP_IS_W-1:0] istat_r;
	logic [`RTP_IS_W-1:0] imask_r;
	logic [`RTP_IS_W-1:0] ievt;
	logic cmd_wr;
	logic pm_wr;

	function automatic rtp_pkg::rtp_reg_type decode(input logic [7:0] a);
		rtp_pkg::rtp_reg_type r;
		unique case (a)
			`RTP_OFS_CMD: r = rtp_pkg::RTP_REG_CMD;
			`RTP_OFS_PERF: r = rtp_pkg::RTP_REG_PERF;
			`RTP_OFS_PMCS: r = rtp_pkg::RTP_REG_PMCS;
			`RTP_OFS_ISTAT: r = rtp_pkg::RTP_REG_ISTAT;
			`RTP_OFS_IMASK: r = rtp_pkg::RTP_REG_IMASK;
			default: r = rtp_pkg::RTP_REG_NONE;
		endcase
		return r;
	endfunction

	// Write address and data are taken in either order and held until the response.
	assign s_axi_awready = clk_en && !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready = clk_en && !w_got_r && !s_axi_bvalid;
	assign wr_fire = clk_en && aw_got_r && w_got_r && !s_axi_bvalid;
	assign wr_sel = decode(wa_r);
	assign cmd_wr = wr_fire && (wr_sel == rtp_pkg::RTP_REG_CMD) && ws_r[0];
	assign pm_wr = wr_fire && (wr_sel == rtp_pkg::RTP_REG_PMCS) && ws_r[1];

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			aw_got_r <= 1'b0;
			wa_r <= 8'h00;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_r <= 1'b1;
				wa_r <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_got_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			w_got_r <= 1'b0;
			wd_r <= 32'h00000000;
			ws_r <= 4'h0;
		end
		else if (clk_en)
		begin
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_r <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_got_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RTP_RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_sel == rtp_pkg::RTP_REG_NONE) ? `RTP_RESP_SLVERR : `RTP_RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Command bits.
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			pause_enable <= `RTP_RST_PAUSE;
		else if (clk_en)
		begin
			if (cmd_wr)
				pause_enable <= wd_r[`RTP_CMD_PAUSE];
			else if (an_done)
				pause_enable <= an_pause;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rx_threshold_enable <= `RTP_RST_RTE;
			rx_drain_threshold <= rtp_pkg::rtp_drain_type'(`RTP_RST_DRT);
			soft_interrupt <= `RTP_RST_SOFT_INTERRUPT;
			auto_underrun_recovery <= `RTP_RST_AUTO_UNDERRUN_RECOVERY;
		end
		else if (clk_en && cmd_wr)
		begin
			rx_threshold_enable <= wd_r[`RTP_CMD_RTE];
			rx_drain_threshold <= rtp_pkg::rtp_drain_type'(wd_r[`RTP_CMD_DRT_HI:`RTP_CMD_DRT_LO]);
			soft_interrupt <= wd_r[`RTP_CMD_SOFT_INTERRUPT];
			auto_underrun_recovery <= wd_r[`RTP_CMD_AUTO_UNDERRUN_RECOVERY];
		end
	end

	// The threshold the receive path really uses.
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			rx_drain_effective <= rtp_pkg::rtp_drain_type'(`RTP_DRT_FIXED);
		else if (clk_en)
		begin
			if (rx_threshold_enable)
				rx_drain_effective <= rx_drain_threshold;
			else
				rx_drain_effective <= rtp_pkg::rtp_drain_type'(`RTP_DRT_FIXED);
		end
	end

	// Performance counters.
	rtp_rc_counter #(.W(16)) u_lat
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.inc(rd_req_active),
		.clr(perf_clr),
		.count(lat_count)
	);

	rtp_rc_counter #(.W(8)) u_dw
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.inc(dw_xfer),
		.clr(perf_clr),
		.count(dw_count)
	);

	// Wake detection and PME#.
	rtp_pin_sync u_wake
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.pin(wake_event_pin),
		.level(wake_level),
		.rise(wake_rise)
	);

	// A wake event in the clearing cycle keeps the bit set.
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			wake_status_r <= 1'b0;
		else if (clk_en)
		begin
			if (wake_rise)
				wake_status_r <= 1'b1;
			else if (pm_wr && wd_r[`RTP_PM_WAKE])
				wake_status_r <= 1'b0;
		end
	end

	// PME# is open drain: driven low only while status and enable are both set.
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			pme_n_oe <= 1'b0;
		else if (clk_en)
			pme_n_oe <= wake_status_r && wake_signal_enable;
	end

	assign pme_n_o = 1'b0;

	// Interrupt status, cleared by its read; a new event wins over the clear.
	assign ievt[`RTP_IS_WAKE] = wake_rise;
	assign ievt[`RTP_IS_SOFT] = cmd_wr && wd_r[`RTP_CMD_SOFT_INTERRUPT];

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			istat_r <= '0;
		else if (clk_en)
			istat_r <= (istat_clr ? '0 : istat_r) | ievt;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			imask_r <= `RTP_RST_MASK;
		else if (clk_en && wr_fire && (wr_sel == rtp_pkg::RTP_REG_IMASK) && ws_r[0])
			imask_r <= wd_r[`RTP_IS_W-1:0];
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(istat_r & imask_r);
	end

	// Read channel.
	assign s_axi_arready = clk_en && (rd_state_r == rtp_pkg::RTP_RD_IDLE);
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_sel = decode(s_axi_araddr);
	assign perf_clr = rd_fire && (rd_sel == rtp_pkg::RTP_REG_PERF);
	assign istat_clr = rd_fire && (rd_sel == rtp_pkg::RTP_REG_ISTAT);

	always_comb
	begin
		rd_word = 32'h00000000;
		unique case (rd_sel)
			rtp_pkg::RTP_REG_CMD:
			begin
				rd_word[`RTP_CMD_PAUSE] = pause_enable;
				rd_word[`RTP_CMD_RTE] = rx_threshold_enable;
				rd_word[`RTP_CMD_DRT_HI:`RTP_CMD_DRT_LO] = rx_drain_threshold;
				rd_word[`RTP_CMD_SOFT_INTERRUPT] = soft_interrupt;
				rd_word[`RTP_CMD_AUTO_UNDERRUN_RECOVERY] = auto_underrun_recovery;
			end
			rtp_pkg::RTP_REG_PERF:
			begin
				rd_word[`RTP_PERF_CLK_HI:`RTP_PERF_CLK_LO] = lat_count;
				rd_word[`RTP_PERF_DW_HI:`RTP_PERF_DW_LO] = dw_count;
			end
			rtp_pkg::RTP_REG_PMCS:
			begin
				rd_word[`RTP_PM_WAKE] = wake_status_r;
				rd_word[`RTP_PM_SCALE_HI:`RTP_PM_SCALE_LO] = `RTP_SCALE_VAL;
				rd_word[`RTP_PM_SEL_HI:`RTP_PM_SEL_LO] = `RTP_SEL_VAL;
				rd_word[`RTP_PM_WSE] = wake_signal_enable;
			end
			rtp_pkg::RTP_REG_ISTAT: rd_word[`RTP_IS_W-1:0] = istat_r;
			rtp_pkg::RTP_REG_IMASK: rd_word[`RTP_IS_W-1:0] = imask_r;
			rtp_pkg::RTP_REG_NONE: rd_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rd_state_r <= rtp_pkg::RTP_RD_IDLE;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RTP_RESP_OKAY;
		end
		else if (clk_en)
		begin
			unique case (rd_state_r)
				rtp_pkg::RTP_RD_IDLE:
				begin
					if (rd_fire)
					begin
						rd_state_r <= rtp_pkg::RTP_RD_RESP;
						s_axi_rdata <= rd_word;
						s_axi_rresp <= (rd_sel == rtp_pkg::RTP_REG_NONE) ? `RTP_RESP_SLVERR : `RTP_RESP_OKAY;
					end
				end
				rtp_pkg::RTP_RD_RESP:
				begin
					if (s_axi_rready)
						rd_state_r <= rtp_pkg::RTP_RD_IDLE;
				end
			endcase
		end
	end

	assign s_axi_rvalid = (rd_state_r == rtp_pkg::RTP_RD_RESP);
endmodule

// ==== hw/rtp_pin_sync.sv ====
// Three-stage synchroniser for one asynchronous pin with a rise pulse.
// Assumes a single clock mclk and a synchronous active-high reset.
`timescale 1ns/100ps
module rtp_pin_sync
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic pin,
	output logic level,
	output logic rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else if (clk_en)
		begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A new level is accepted only once the second and third stage agree.
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			level <= 1'b0;
			rise <= 1'b0;
		end
		else if (clk_en)
		begin
			rise <= (s2_r == s3_r) && s3_r && !level;
			if (s2_r == s3_r)
				level <= s3_r;
		end
	end
endmodule

// ==== hw/rtp_pkg.sv ====
// Types shared by the register slice, its monitor and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package rtp_pkg;

	typedef enum logic [1:0] {
		RTP_DRT_32B,
		RTP_DRT_64B,
		RTP_DRT_SAF,
		RTP_DRT_RSV
	} rtp_drain_type;

	typedef enum logic [2:0] {
		RTP_REG_NONE,
		RTP_REG_CMD,
		RTP_REG_PERF,
		RTP_REG_PMCS,
		RTP_REG_ISTAT,
		RTP_REG_IMASK
	} rtp_reg_type;

	typedef enum logic {
		RTP_RD_IDLE,
		RTP_RD_RESP
	} rtp_rd_state_type;

endpackage

// ==== hw/rtp_rc_counter.sv ====
// Saturating event counter that clears when its register is read.
// Assumes inc and clr come from logic on mclk.
`timescale 1ns/100ps
module rtp_rc_counter
#(
	parameter int W = 8
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic inc,
	input wire logic clr,
	output logic [W-1:0] count
);
	// An event in the clearing cycle is kept as the first count of the new total.
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			count <= '0;
		else if (clk_en)
		begin
			if (clr)
				count <= {{(W-1){1'b0}}, inc};
			else if (inc && !(&count))
				count <= count + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ==== verification/rtp_csr_monitor.sv ====
// Checker for the register slice, seeing only the top module ports.
// Assumes a bind onto rtp_csr_top and the single clock mclk.
`timescale 1ns/100ps
`include "rtp_cfg.svh"
module rtp_csr_monitor
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic an_done,
	input wire logic an_pause,
	input wire logic wake_signal_enable,
	input wire logic pause_enable,
	input wire logic rx_threshold_enable,
	input wire logic [1:0] rx_drain_threshold,
	input wire logic [1:0] rx_drain_effective,
	input wire logic pme_n_oe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	a_pme_gated: assert property (pme_n_oe |-> $past(wake_signal_enable))
		else $error("PME driven while wake signalling disabled");
	a_drain_fixed: assert property (!rx_threshold_enable |=> rx_drain_effective == rtp_pkg::RTP_DRT_64B)
		else $error("Drain threshold not fixed while selection disabled");
	a_drain_select: assert property (rx_threshold_enable |=> rx_drain_effective == $past(rx_drain_threshold))
		else $error("Drain threshold does not follow the field");
	a_pause_load: assert property (an_done && !s_axi_awvalid && !s_axi_wvalid |=> pause_enable == $past(an_pause))
		else $error("Pause enable did not load the negotiated value");
	a_pm_fixed: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `RTP_OFS_PMCS |=>
		s_axi_rdata[14:9] == 6'h00)
		else $error("Unsupported data fields not zero");
	a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=>
		s_axi_rvalid && s_axi_rresp == `RTP_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("Unmapped read not refused");
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped before handshake");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data changed before handshake");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("Read address accepted while response pending");
	a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
		##2 s_axi_bvalid)
		else $error("Write response late");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_pme: cover property (pme_n_oe);
	c_saf: cover property (rx_threshold_enable && rx_drain_effective == rtp_pkg::RTP_DRT_SAF);
endmodule

// ==== verification/rtp_csr_top_tb.sv ====
// Self-checking bench for the register slice over AXI4-Lite.
// Assumes the monitor and host model files are compiled before this one.
`timescale 1ns/100ps
`define CHK(n, e, g) \
	begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module rtp_csr_top_tb;
	logic mclk = 0, sys_rst = 1, clk_en = 1, go = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, lat = 0, dws = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic an_done = 0, an_pause = 0, wake_event_pin = 0, wake_signal_enable = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pause_enable;
	logic rx_threshold_enable, soft_interrupt, auto_underrun_recovery, pme_n_o, pme_n_oe, irq;
	logic rd_req_active, dw_xfer;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	rtp_pkg::rtp_drain_type rx_drain_threshold, rx_drain_effective;
	int err_count = 0, total_checks = 0, cyc = 0, i;
	rtp_csr_top uut (.mclk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .an_done,
		.an_pause, .rd_req_active, .dw_xfer, .wake_event_pin, .wake_signal_enable, .pause_enable,
		.rx_threshold_enable, .rx_drain_threshold, .rx_drain_effective, .soft_interrupt,
		.auto_underrun_recovery, .pme_n_o, .pme_n_oe, .irq);
	rtp_host_model host (.mclk, .go, .lat, .dws, .rd_req_active, .dw_xfer);
	always #20 mclk = ~mclk;
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count++;
			close_out();
		end
	end
	// Response ready is raised only after valid is seen, so the slave must hold its answer.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_t, w_t, bv, done;
		logic [1:0] r;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		done = 1'b0;
		while (!done)
		begin
			@(negedge mclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			bv = s_axi_bvalid;
			done = bv && s_axi_bready;
			r = s_axi_bresp;
			@(posedge mclk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
			s_axi_bready <= bv && !done;
		end
		`CHK("bresp", er, r)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string nm);
		logic ar_t, rv, done;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		done = 1'b0;
		while (!done)
		begin
			@(negedge mclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			done = rv && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk);
			if (ar_t)
				s_axi_arvalid <= 1'b0;
			s_axi_rready <= rv && !done;
		end
		`CHK(nm, ed, d)
		`CHK("rresp", er, r)
	endtask
	initial
	begin
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(8'h88, 32'h4, 2'h0, "cmd_reset");
		rd(8'h8c, 32'h0, 2'h0, "perf_reset");
		rd(8'h00, 32'h0, 2'h2, "unmapped");
		wr(8'h04, 32'hffffffff, 2'h2);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h88, 32'h10 | 32'(i << 2), 2'h0);
			@(negedge mclk);
			`CHK("drain_sel", 2'(i), rx_drain_effective)
		end
		wr(8'h88, 32'h8, 2'h0);
		@(negedge mclk);
		`CHK("drain_fixed", 2'h1, rx_drain_effective)
		rd(8'h88, 32'h8, 2'h0, "cmd_back");
		@(posedge mclk);
		an_pause <= 1'b1;
		an_done <= 1'b1;
		@(posedge mclk);
		an_done <= 1'b0;
		@(negedge mclk);
		`CHK("pause_an", 1'b1, pause_enable)
		wr(8'h88, 32'h1, 2'h0);
		@(negedge mclk);
		`CHK("pause_sw", 1'b0, pause_enable)
		`CHK("underrun", 1'b1, auto_underrun_recovery)
		wr(8'h98, 32'h3, 2'h0);
		wr(8'h88, 32'h2, 2'h0);
		repeat (2) @(negedge mclk);
		`CHK("soft_int", 1'b1, soft_interrupt)
		`CHK("irq_soft", 1'b1, irq)
		rd(8'h94, 32'h2, 2'h0, "irq_status");
		wr(8'h88, 32'h0, 2'h0);
		repeat (2) @(negedge mclk);
		`CHK("irq_clear", 1'b0, irq)
		`CHK("soft_off", 1'b0, soft_interrupt)
		@(posedge mclk);
		lat <= 8'h05;
		dws <= 8'h03;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (10) @(posedge mclk);
		rd(8'h8c, 32'h00050003, 2'h0, "perf_count");
		wr(8'h8c, 32'hffffffff, 2'h0);
		rd(8'h8c, 32'h0, 2'h0, "perf_cleared");
		// Bus-master activity while the enable is low must leave the counters untouched.
		clk_en <= 1'b0;
		lat <= 8'h04;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (6) @(posedge mclk);
		clk_en <= 1'b1;
		rd(8'h8c, 32'h0, 2'h0, "perf_frozen");
		wr(8'h98, 32'h0, 2'h0);
		wake_event_pin <= 1'b1;
		repeat (8) @(negedge mclk);
		`CHK("irq_masked", 1'b0, irq)
		`CHK("pme_gated", 1'b0, pme_n_oe)
		rd(8'h90, 32'h8000, 2'h0, "wake_set");
		rd(8'h94, 32'h1, 2'h0, "irq_wake");
		wake_signal_enable <= 1'b1;
		repeat (2) @(negedge mclk);
		`CHK("pme_on", 1'b1, pme_n_oe)
		`CHK("pme_level", 1'b0, pme_n_o)
		wr(8'h90, 32'h0100, 2'h0);
		rd(8'h90, 32'h8100, 2'h0, "wake_kept");
		wr(8'h90, 32'h8000, 2'h0);
		repeat (2) @(negedge mclk);
		`CHK("pme_off", 1'b0, pme_n_oe)
		rd(8'h90, 32'h0100, 2'h0, "wake_clear");
		close_out();
	end
endmodule
bind rtp_csr_top rtp_csr_monitor mon (.mclk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .an_done, .an_pause, .wake_signal_enable,
	.pause_enable, .rx_threshold_enable, .rx_drain_threshold, .rx_drain_effective, .pme_n_oe);

// ==== verification/rtp_host_model.sv ====
// Bus-master activity model: a read request and a burst of double words.
// Assumes go is a one-cycle pulse on mclk carrying the two lengths.
`timescale 1ns/100ps
module rtp_host_model
(
	input wire logic mclk,
	input wire logic go,
	input wire logic [7:0] lat,
	input wire logic [7:0] dws,
	output logic rd_req_active,
	output logic dw_xfer
);
	logic [7:0] lat_r = 8'h00;
	logic [7:0] dw_r = 8'h00;
	// Request stays up lat cycles, one double word moves per cycle for dws cycles.
	always_ff @(posedge mclk)
	begin
		lat_r <= go ? lat : (lat_r != 8'h00 ? lat_r - 8'h01 : 8'h00);
		dw_r <= go ? dws : (dw_r != 8'h00 ? dw_r - 8'h01 : 8'h00);
	end
	assign rd_req_active = lat_r != 8'h00;
	assign dw_xfer = dw_r != 8'h00;
endmodule
